// File: hdl/fcs_pkg.sv
// Package for the flash code security gate.
// Assumes one processor clock domain and byte-wide special registers.
package fcs_pkg;
   // Register addresses
   localparam logic [7:0]  SECCTL_ADDR  = 8'hB2;
   localparam logic [15:0] SYSCFG1_ADDR = 16'h2005;
   // Field positions in flash_security_control
   localparam int BOOT_FLAG_BIT  = 7;
   localparam int PROTECT_BIT    = 6;
   localparam int MEM_EN_BIT     = 1;
   localparam int PAGE_WR_EN_BIT = 0;
   // Field positions in system_config_one
   localparam int ECLK_OFF_BIT   = 5;
   // Reset values
   localparam logic [7:0] SECCTL_RESET  = 8'h00;
   localparam logic [7:0] SYSCFG1_RESET = 8'h00;
   // Boot-lock length in processor cycles
   localparam int BOOT_LOCK_CYCLES = 32;
   localparam logic [5:0] BOOT_LOCK_LAST = 6'(BOOT_LOCK_CYCLES - 1);
   // Flash page holding the boot code
   localparam logic [6:0] PAGE_ZERO = 7'h00;

   // Emulator operation codes
   typedef enum logic [2:0] {
      FCS_OP_NONE, FCS_OP_BULK_ERASE, FCS_OP_PAGE_ERASE,
      FCS_OP_WRITE, FCS_OP_READ, FCS_OP_HALT
   } fcs_op_t;

   // Request toward flash from either master
   typedef struct packed {
      logic       valid;
      fcs_op_t    op;
      logic [6:0] page;
   } fcs_req_t;

   // Verdict on a request
   typedef struct packed {
      logic    grant;
      logic    refuse;
      fcs_op_t op;
   } fcs_ans_t;
endpackage

// File: hdl/fcs_gate.sv
// Flash code security gate: boot-lock timer, set-only protect latch and
// the filter that grants or refuses flash work for processor and emulator.
// Assumes the processor core presents special-register accesses as
// single-cycle strobes synchronous to clk_sys.
//
// Function
// - First 32 cycles after reset are boot-lock; emulator port held off
// - Boot-lock flag readable at bit 7 of security control, high then
// - After boot-lock the emulator may be enabled and take the core
// - Protect latch clears to zero on every processor reset
// - Protect latch is set-only: ones set it, zeros change nothing
// - Boot code enables protection by setting latch during boot-lock
// - With latch set, emulator may only bulk erase
// - With latch set, no external code read from flash
// - With latch set, page zero cannot be page-erased by anyone
// - With latch set, writes to page zero are inhibited
// - Global erase also clears engine program RAM, latch or not
// - Only a chip reset removes protection; global erase does not clear the latch
// - Emulator clock off bit stops emulator clock and access
`timescale 1ns/100ps
module fcs_gate (
   // Clock and reset
   input  wire  logic             clk_sys,
   input  wire  logic             rst_n,
   // Special register port
   input  wire  logic             sfr_wr,
   input  wire  logic             sfr_rd,
   input  wire  logic [7:0]       sfr_addr,
   input  wire  logic [7:0]       sfr_wdata,
   output       logic [7:0]       sfr_rdata,
   // Configuration memory port
   input  wire  logic             cfg_wr,
   input  wire  logic [15:0]      cfg_addr,
   input  wire  logic [7:0]       cfg_wdata,
   output       logic [7:0]       cfg_rdata,
   // Emulator side
   input  wire  logic             emu_enable,
   input  wire  fcs_pkg::fcs_req_t emu_req,
   output       fcs_pkg::fcs_ans_t emu_ans,
   output       logic             emu_clk_en,
   output       logic             emu_core_ctl,
   // Processor flash requests
   input  wire  fcs_pkg::fcs_req_t cpu_req,
   output       fcs_pkg::fcs_ans_t cpu_ans,
   // Flash and engine memory controls
   output       logic             flash_bulk_erase,
   output       logic             engine_program_ram_clear,
   output       logic             code_protect_latch,
   output       logic             boot_lock_phase_flag
);

   logic [5:0] lock_cnt_reg;
   logic       boot_lock_reg;
   logic       protect_reg;
   logic [1:0] flash_ctl_reg;
   logic [7:0] syscfg1_reg;
   logic       sec_wr;
   logic       cfg1_wr;

   // Verdict on one request; page zero is sacred once protected
   function automatic logic fcs_allowed(input fcs_pkg::fcs_req_t r,
                                        input logic prot,
                                        input logic from_emu);
      logic pz;
      pz = (r.page == fcs_pkg::PAGE_ZERO);
      fcs_allowed = 1'b1;
      if (prot && from_emu && r.op != fcs_pkg::FCS_OP_BULK_ERASE)
         fcs_allowed = 1'b0;
      if (prot && from_emu && r.op == fcs_pkg::FCS_OP_READ)
         fcs_allowed = 1'b0;
      if (prot && pz && r.op == fcs_pkg::FCS_OP_PAGE_ERASE)
         fcs_allowed = 1'b0;
      if (prot && pz && r.op == fcs_pkg::FCS_OP_WRITE)
         fcs_allowed = 1'b0;
   endfunction

   assign sec_wr  = sfr_wr && (sfr_addr == fcs_pkg::SECCTL_ADDR);
   assign cfg1_wr = cfg_wr && (cfg_addr == fcs_pkg::SYSCFG1_ADDR);

   // Boot-lock counter; runs once per reset then parks
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lock_cnt_reg  <= 6'h00;
         boot_lock_reg <= 1'b1;
      end else if (boot_lock_reg) begin
         lock_cnt_reg <= lock_cnt_reg + 6'h01;
         if (lock_cnt_reg == fcs_pkg::BOOT_LOCK_LAST) begin
            boot_lock_reg <= 1'b0;
         end
      end
   end

   // Protect latch; only reset clears it, so erase alone is not enough
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         protect_reg <= 1'b0;
      end else if (sec_wr && sfr_wdata[fcs_pkg::PROTECT_BIT]) begin
         protect_reg <= 1'b1;
      end
   end

   // Plain flash control bits kept beside the latch
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flash_ctl_reg <= 2'h0;
      end else if (sec_wr) begin
         flash_ctl_reg <= {sfr_wdata[fcs_pkg::MEM_EN_BIT],
                           sfr_wdata[fcs_pkg::PAGE_WR_EN_BIT]};
      end
   end

   // System configuration byte holding the emulator clock off bit
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         syscfg1_reg <= fcs_pkg::SYSCFG1_RESET;
      end else if (cfg1_wr) begin
         syscfg1_reg <= cfg_wdata;
      end
   end

   // Register read data, registered; unmapped addresses read zero
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata <= fcs_pkg::SECCTL_RESET;
         cfg_rdata <= fcs_pkg::SYSCFG1_RESET;
      end else begin
         sfr_rdata <= 8'h00;
         if (sfr_rd && sfr_addr == fcs_pkg::SECCTL_ADDR) begin
            sfr_rdata[fcs_pkg::BOOT_FLAG_BIT]  <= boot_lock_reg;
            sfr_rdata[fcs_pkg::PROTECT_BIT]    <= protect_reg;
            sfr_rdata[fcs_pkg::MEM_EN_BIT]     <= flash_ctl_reg[1];
            sfr_rdata[fcs_pkg::PAGE_WR_EN_BIT] <= flash_ctl_reg[0];
         end
         cfg_rdata <= (cfg_addr == fcs_pkg::SYSCFG1_ADDR) ?
                      syscfg1_reg : 8'h00;
      end
   end

   // Emulator access: none in boot-lock or with its clock stopped
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         emu_clk_en   <= 1'b0;
         emu_core_ctl <= 1'b0;
         emu_ans      <= '0;
      end else begin
         emu_clk_en   <= !syscfg1_reg[fcs_pkg::ECLK_OFF_BIT];
         emu_core_ctl <= emu_enable && !boot_lock_reg &&
                         !protect_reg &&
                         !syscfg1_reg[fcs_pkg::ECLK_OFF_BIT];
         emu_ans.op   <= emu_req.op;
         if (emu_req.valid && !boot_lock_reg && emu_enable &&
             !syscfg1_reg[fcs_pkg::ECLK_OFF_BIT]) begin
            emu_ans.grant  <= fcs_allowed(emu_req, protect_reg, 1'b1);
            emu_ans.refuse <= !fcs_allowed(emu_req, protect_reg, 1'b1);
         end else begin
            emu_ans.grant  <= 1'b0;
            emu_ans.refuse <= emu_req.valid;
         end
      end
   end

   // Processor requests: only the page zero limits apply
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cpu_ans <= '0;
      end else begin
         cpu_ans.op     <= cpu_req.op;
         cpu_ans.grant  <= cpu_req.valid &&
                           fcs_allowed(cpu_req, protect_reg, 1'b0);
         cpu_ans.refuse <= cpu_req.valid &&
                           !fcs_allowed(cpu_req, protect_reg, 1'b0);
      end
   end

   // Global erase pulses; engine program RAM goes with the flash
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flash_bulk_erase <= 1'b0;
         engine_program_ram_clear       <= 1'b0;
      end else begin
         flash_bulk_erase <= (emu_req.valid && !boot_lock_reg &&
                              emu_enable &&
                              !syscfg1_reg[fcs_pkg::ECLK_OFF_BIT] &&
                              emu_req.op == fcs_pkg::FCS_OP_BULK_ERASE) ||
                             (cpu_req.valid &&
                              cpu_req.op == fcs_pkg::FCS_OP_BULK_ERASE);
         engine_program_ram_clear       <= (emu_req.valid && !boot_lock_reg &&
                              emu_enable &&
                              !syscfg1_reg[fcs_pkg::ECLK_OFF_BIT] &&
                              emu_req.op == fcs_pkg::FCS_OP_BULK_ERASE) ||
                             (cpu_req.valid &&
                              cpu_req.op == fcs_pkg::FCS_OP_BULK_ERASE);
      end
   end

   // Status copies straight from flops
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         code_protect_latch   <= 1'b0;
         boot_lock_phase_flag <= 1'b1;
      end else begin
         code_protect_latch   <= protect_reg;
         boot_lock_phase_flag <= boot_lock_reg;
      end
   end

endmodule

// File: verif/fcs_gate_checker.sv
// Port assertions for the flash code security gate.
// Bound onto fcs_gate; one clock, async active-low reset.
`timescale 1ns/100ps
module fcs_gate_checker (
   // Clock, reset, register port
   input wire logic              clk_sys,
   input wire logic              rst_n,
   input wire logic              sfr_wr,
   input wire logic [7:0]        sfr_addr,
   input wire logic [7:0]        sfr_wdata,
   // Requests, answers, controls
   input wire fcs_pkg::fcs_req_t cpu_req,
   input wire fcs_pkg::fcs_ans_t cpu_ans,
   input wire fcs_pkg::fcs_ans_t emu_ans,
   input wire logic              emu_clk_en,
   input wire logic              emu_core_ctl,
   input wire logic              flash_bulk_erase,
   input wire logic              engine_program_ram_clear,
   input wire logic              code_protect_latch,
   input wire logic              boot_lock_phase_flag
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Outputs are registered alike, so flag and answers share a cycle
   property p_hold; code_protect_latch |=> code_protect_latch; endproperty
   a_hold: assert property (p_hold) else $error("latch cleared");
   property p_set; sfr_wr && sfr_addr == fcs_pkg::SECCTL_ADDR
      && sfr_wdata[6] |-> ##2 code_protect_latch; endproperty
   a_set: assert property (p_set) else $error("latch not set");
   property p_pg0; code_protect_latch && $past(cpu_req.valid
      && cpu_req.page == fcs_pkg::PAGE_ZERO && cpu_req.op inside
      {fcs_pkg::FCS_OP_WRITE, fcs_pkg::FCS_OP_PAGE_ERASE})
      |-> cpu_ans.refuse; endproperty
   a_pg0: assert property (p_pg0) else $error("page zero open");
   property p_only; code_protect_latch && emu_ans.grant
      |-> emu_ans.op == fcs_pkg::FCS_OP_BULK_ERASE; endproperty
   a_only: assert property (p_only) else $error("emu op leaked");
   property p_engine_program_ram; flash_bulk_erase == engine_program_ram_clear; endproperty
   a_engine_program_ram: assert property (p_engine_program_ram) else $error("ram clear apart");
   property p_clk; !emu_clk_en |-> !emu_core_ctl; endproperty
   a_clk: assert property (p_clk) else $error("core with clk off");
   property p_boot; emu_ans.grant |-> !boot_lock_phase_flag; endproperty
   a_boot: assert property (p_boot) else $error("grant in boot");
   property p_core; emu_core_ctl
      |-> !code_protect_latch && !boot_lock_phase_flag; endproperty
   a_core: assert property (p_core) else $error("core ctl leak");
   c_prot: cover property (code_protect_latch && emu_ans.grant);
   c_ref: cover property (cpu_ans.refuse);
   c_end: cover property ($fell(boot_lock_phase_flag));
endmodule
bind fcs_gate fcs_gate_checker fcs_gate_checker_inst (.*);

// File: verif/fcs_emu_model.sv
// Emulator stand-in: turns bench commands into one-cycle requests.
// Assumes commands change just after the rising edge.
`timescale 1ns/100ps
module fcs_emu_model (
   input  wire logic              clk_sys,
   input  wire logic              go,
   input  wire logic [2:0]        op,
   input  wire logic [6:0]        page,
   output      fcs_pkg::fcs_req_t emu_req
);
   // Idle cycles scramble the page so a gate ignoring valid shows up;
   // the gate is held in reset until this has run for many edges
   always @(posedge clk_sys) begin
      if (go) begin
         emu_req <= {1'b1, fcs_pkg::fcs_op_t'(op), page};
      end else begin
         emu_req <= {1'b0, fcs_pkg::FCS_OP_NONE, ~emu_req.page};
      end
   end
endmodule

// File: verif/flash_code_security_gate_tb_top.sv
// Bench for the flash code security gate and emulator stand-in.
// Answers are matched in order against a queue of expected verdicts.
`timescale 1ns/100ps
module flash_code_security_gate_tb_top;
   logic clk_sys = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, cfg_wr = 0;
   logic emu_enable = 0, go = 0, bulk, engine_program_ram;
   logic [7:0] sfr_wdata = 0, cfg_wdata = 0, sfr_rdata;
   logic [6:0] page = 0;
   logic ck, cc, lt, bf;
   logic [7:0] cfg_rdata;
   logic [2:0] op = 0, exp_q[$];
   fcs_pkg::fcs_req_t cpu_req = '0, emu_req;
   fcs_pkg::fcs_ans_t cpu_ans, emu_ans;
   int error_cnt = 0, num_checks = 0, seed = 2;
   always #25 clk_sys = ~clk_sys;
   fcs_emu_model fcs_emu_model_inst (.clk_sys(clk_sys), .go(go), .op(op),
      .page(page), .emu_req(emu_req));
   fcs_gate fcs_gate_inst (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_addr(fcs_pkg::SECCTL_ADDR), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .cfg_wr(cfg_wr), .cfg_addr(fcs_pkg::SYSCFG1_ADDR),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .emu_enable(emu_enable),
      .emu_req(emu_req), .emu_ans(emu_ans), .emu_clk_en(ck),
      .emu_core_ctl(cc), .cpu_req(cpu_req), .cpu_ans(cpu_ans),
      .flash_bulk_erase(bulk), .engine_program_ram_clear(engine_program_ram), .code_protect_latch(lt),
      .boot_lock_phase_flag(bf));
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      if (exp_q.size() != 0) error_cnt++;
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic boot();
      @(posedge clk_sys);
      rst_n <= 0;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1;
   endtask
   // Expected verdict is {grant, refuse, erase pulse}
   task automatic req(bit e, logic [2:0] o, logic [6:0] p, logic [2:0] x);
      @(posedge clk_sys);
      if (e) begin
         go <= 1;
         op <= o;
         page <= p;
      end else cpu_req <= {1'b1, fcs_pkg::fcs_op_t'(o), p};
      exp_q.push_back(x);
      @(posedge clk_sys);
      go <= 0;
      cpu_req <= '0;
   endtask
   task automatic wr(bit c, logic [7:0] d);
      @(posedge clk_sys);
      if (c) cfg_wr <= 1;
      else sfr_wr <= 1;
      cfg_wdata <= d;
      sfr_wdata <= d;
      @(posedge clk_sys);
      cfg_wr <= 0;
      sfr_wr <= 0;
   endtask
   task automatic rd(logic [7:0] e);
      @(posedge clk_sys);
      sfr_rd <= 1;
      @(posedge clk_sys);
      sfr_rd <= 0;
      #1 chk(sfr_rdata, e);
   endtask
   // Each answer pulse takes the oldest expectation
   always @(posedge clk_sys) begin
      if ((emu_ans.grant | emu_ans.refuse | cpu_ans.grant | cpu_ans.refuse)
         === 1'b1) begin
         chk(8'({emu_ans.grant | cpu_ans.grant, emu_ans.refuse |
            cpu_ans.refuse, bulk & engine_program_ram}),
            8'(exp_q.size() > 0 ? exp_q.pop_front() : 3'h7));
      end
   end
   initial begin
      boot();
      emu_enable <= 1;
      req(1, 3'h1, 0, 3'h2);
      rd(8'h80);
      repeat (40) @(posedge clk_sys);
      rd(8'h00);
      chk(8'({ck, cc, lt, bf}), 8'h0C);
      for (int i = 1; i < 6; i++) req(1, 3'(i), 7'(i), i == 1 ? 3'h5 : 3'h4);
      wr(1, 8'h20);
      @(posedge clk_sys);
      #1 chk(8'({ck, cc, lt, bf}), 8'h00);
      chk(cfg_rdata, 8'h20);
      req(1, 3'h4, 0, 3'h2);
      wr(1, 8'h00);
      wr(0, 8'h00);
      rd(8'h00);
      $display("open device test done");
      boot();
      wr(0, 8'h40);
      rd(8'hC0);
      repeat (40) @(posedge clk_sys);
      #1 chk(8'({ck, cc, lt, bf}), 8'h0A);
      for (int i = 1; i < 6; i++) req(1, 3'(i), 7'(i), i == 1 ? 3'h5 : 3'h2);
      req(0, 3'h2, 0, 3'h2);
      req(0, 3'h3, 0, 3'h2);
      req(0, 3'h3, 7'(1 + {$random(seed)} % 127), 3'h4);
      req(0, 3'h1, 0, 3'h5);
      wr(0, 8'h00);
      rd(8'h40);
      $display("protected device test done");
      boot();
      rd(8'h80);
      chk(8'({ck, cc, lt, bf}), 8'h09);
      repeat (4) @(posedge clk_sys);
      $display("reset test done");
      test_done();
   end
   initial begin
      repeat (2000) @(posedge clk_sys);
      error_cnt++;
      test_done();
   end
endmodule
